// ### mfi_defines.vh
`ifndef MFI_DEFINES_VH
`define MFI_DEFINES_VH

// Bus register byte offsets
`define OFS_FUNC_LO        12'h000
`define OFS_FUNC_HI        12'h004
`define OFS_FILTER         12'h008
`define OFS_CTRL           12'h00C
`define OFS_TERM           12'h010
`define OFS_CMD            12'h014
`define OFS_IRQ_STAT       12'h018
`define OFS_IRQ_MASK       12'h01C

// Function codes
`define FN_LEN_RESET       6'd28
`define FN_PULSE_IN        6'd30
`define FN_DC_BRAKE        6'd32
`define FN_EXT_FAULT_NC    6'd33
`define FN_PID_REVERSE     6'd35
`define FN_EXT_STOP1       6'd36
`define FN_CMD_SWITCH      6'd37
`define FN_PID_INT_HOLD    6'd38
`define FN_SRC_X_KEYPAD    6'd39
`define FN_SRC_Y_KEYPAD    6'd40
`define FN_PID_GAIN_SEL    6'd43
`define FN_EMERG_STOP      6'd47
`define FN_EXT_STOP2       6'd48
`define FN_EXT_FAULT_NO    6'd11

// Command source modes
`define CMD_SRC_PANEL      2'd0
`define CMD_SRC_TERMINAL   2'd1
`define CMD_SRC_COMM       2'd2

// Control register fields
`define CTRL_CMD_SRC_LO    0
`define CTRL_CMD_SRC_HI    1
`define CTRL_PID_DIR       2
`define CTRL_GAIN_BY_TERM  3

// Deceleration set for external stop 2
`define DECEL_SET_STOP2    2'd3

// Filter time in microseconds, clock in MHz
`define FILTER_DEFAULT_US  32'd10000
`define FILTER_MAX_US      32'd1000000
`define CLK_MHZ            32'd100

// Reset values
`define RST_FUNC_LO        32'h0000_0000
`define RST_FUNC_HI        32'h0000_0000
`define RST_CTRL           32'h0000_0000
`define RST_MASK           32'h0000_0000

`endif

// ### input_sync_filter.v
`timescale 1ns/100ps
`default_nettype none

module input_sync_filter (
    // Clock and reset
    input  wire        clk,
    input  wire        resetn,
    // Raw pin and filter length
    input  wire        pin,
    input  wire [27:0] filt_cycles,
    // Filtered level
    output reg         level_r
);

    reg        sync1_r;
    reg        sync2_r;
    reg [27:0] cnt_r;

    // Two-stage synchroniser, then stability counter
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            cnt_r   <= 28'h000_0000;
            level_r <= 1'b0;
        end else begin
            sync1_r <= pin;
            sync2_r <= sync1_r;
            if (sync2_r == level_r) begin
                cnt_r <= 28'h000_0000;
            end else if (cnt_r >= filt_cycles) begin
                // Zero filter time passes changes after sync only
                level_r <= sync2_r;
                cnt_r   <= 28'h000_0000;
            end else begin
                cnt_r <= cnt_r + 28'h000_0001;
            end
        end
    end

endmodule

`default_nettype wire

// ### func_lookup.v
`timescale 1ns/100ps
`default_nettype none

module func_lookup (
    // Clock and reset
    input  wire        clk,
    input  wire        resetn,
    // Codes per terminal and filtered levels
    input  wire [29:0] codes,
    input  wire [4:0]  levels,
    // Active terminals per function
    output reg  [63:0] fn_active_r
);

    integer    i;
    reg [63:0] nxt;

    // One-hot OR of the assigned function of every terminal whose level is high
    always @* begin
        nxt = 64'h0000_0000_0000_0000;
        for (i = 0; i < 5; i = i + 1) begin
            if (levels[i]) begin
                nxt[codes[i*6 +: 6]] = 1'b1;
            end
        end
    end

    // Registered so downstream sees a clean level
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fn_active_r <= 64'h0000_0000_0000_0000;
        end else begin
            fn_active_r <= nxt;
        end
    end

endmodule

`default_nettype wire

// ### input_terminal_function_decoder.v
`timescale 1ns/100ps
`default_nettype none
`include "mfi_defines.vh"

module input_terminal_function_decoder (
    // Clock and reset
    input  wire        clk,
    input  wire        resetn,
    // Terminal pins
    input  wire [4:0]  multifunction_input,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Control core strobes
    output reg         pulse_freq_en,
    output reg         pulse_freq_in,
    output reg         dc_brake_now,
    output reg         external_fault_code,
    output reg         fault_stop,
    output reg         fault_protect_req,
    output reg         pid_dir_reverse,
    output reg         panel_stop,
    output reg [1:0]   cmd_source,
    output reg         pid_int_hold,
    output reg         src_x_keypad,
    output reg         src_y_keypad,
    output reg         pid_gain_set2,
    output reg         emerg_stop,
    output reg         decel_stop,
    output reg [1:0]   decel_set,
    output reg         length_reset,
    // Interrupt
    output reg         irq
);

    // Register state
    reg  [31:0] func_lo_r;
    reg  [31:0] func_hi_r;
    reg  [31:0] filter_us_r;
    reg  [31:0] ctrl_r;
    reg  [7:0]  irq_stat_r;
    reg  [7:0]  irq_mask_r;
    reg         cmd_toggle_r;
    reg         pulse_s1_r;
    reg         pulse_s2_r;
    wire [4:0]  level;
    wire [63:0] fn;
    wire [29:0] codes;
    wire [5:0]  code_t1;
    wire [5:0]  code_t2;
    wire [5:0]  code_t3;
    wire [5:0]  code_t4;
    wire [5:0]  code_t5;
    wire [31:0] filt_full;
    wire [27:0] filt_cycles;
    wire        wr_en;
    wire        rd_en;
    reg  [7:0]  irq_evt;
    reg  [31:0] rd_nxt;
    reg         addr_ok;
    reg         fault_nxt;
    reg  [1:0]  src_nxt;

    // Code fields per terminal; terminal five sits alone in the high word
    assign code_t1 = func_lo_r[5:0];
    assign code_t2 = func_lo_r[11:6];
    assign code_t3 = func_lo_r[17:12];
    assign code_t4 = func_lo_r[29:24];
    assign code_t5 = func_hi_r[5:0];
    assign codes   = {code_t5, code_t4, code_t3, code_t2, code_t1};
    // Microseconds to cycles; one second still fits in 28 bits
    assign filt_full   = filter_us_r * `CLK_MHZ;
    assign filt_cycles = filt_full[27:0];
    // Transfer completes on the edge that sees pready high
    assign wr_en = psel & penable & pwrite & pready;
    assign rd_en = psel & penable & ~pwrite & pready;

    // One filter length is shared by all five terminals
    // per-pin debounce
    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : gen_filt
            input_sync_filter u_filt (
                .clk         (clk),
                .resetn      (resetn),
                .pin         (multifunction_input[g]),
                .filt_cycles (filt_cycles),
                .level_r     (level[g])
            );
        end
    endgenerate

    func_lookup u_lookup (
        .clk         (clk),
        .resetn      (resetn),
        .codes       (codes),
        .levels      (level),
        .fn_active_r (fn)
    );

    // Raw pulse path for terminal five, synchronised but unfiltered
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pulse_s1_r <= 1'b0;
            pulse_s2_r <= 1'b0;
        end else begin
            pulse_s1_r <= multifunction_input[4];
            pulse_s2_r <= pulse_s1_r;
        end
    end

    // Address decode and read mux
    always @* begin
        addr_ok = 1'b1;
        rd_nxt  = 32'h0000_0000;
        case (paddr)
            `OFS_FUNC_LO:  rd_nxt = func_lo_r;
            `OFS_FUNC_HI:  rd_nxt = func_hi_r;
            `OFS_FILTER:   rd_nxt = filter_us_r;
            `OFS_CTRL:     rd_nxt = ctrl_r;
            `OFS_TERM:     rd_nxt = {27'h000_0000, level};
            `OFS_CMD:      rd_nxt = {30'h0000_0000, cmd_source};
            `OFS_IRQ_STAT: rd_nxt = {24'h00_0000, irq_stat_r};
            `OFS_IRQ_MASK: rd_nxt = {24'h00_0000, irq_mask_r};
            default:       addr_ok = 1'b0;
        endcase
    end

    // Function outputs, next values
    always @* begin
        fault_nxt = fn[`FN_EXT_FAULT_NC] | fn[`FN_EXT_FAULT_NO];
        src_nxt   = ctrl_r[`CTRL_CMD_SRC_HI:`CTRL_CMD_SRC_LO];
        if (cmd_toggle_r) begin
            if (src_nxt == `CMD_SRC_TERMINAL) begin
                src_nxt = `CMD_SRC_COMM;
            end else if (src_nxt == `CMD_SRC_COMM) begin
                src_nxt = `CMD_SRC_TERMINAL;
            end
        end
        // Code 3 names no source; fall back to panel so the output stays legal
        if (src_nxt == 2'h3) begin
            src_nxt = `CMD_SRC_PANEL;
        end
        irq_evt[0] = fn[`FN_LEN_RESET];
        irq_evt[1] = fn[`FN_CMD_SWITCH];
        irq_evt[2] = fn[`FN_EXT_FAULT_NC];
        irq_evt[3] = fn[`FN_EXT_FAULT_NO];
        irq_evt[4] = fn[`FN_DC_BRAKE];
        irq_evt[5] = fn[`FN_EXT_STOP1];
        irq_evt[6] = fn[`FN_EMERG_STOP];
        irq_evt[7] = fn[`FN_EXT_STOP2];
    end

    // APB registers; one wait state gives registered read data
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            func_lo_r   <= `RST_FUNC_LO;
            func_hi_r   <= `RST_FUNC_HI;
            filter_us_r <= `FILTER_DEFAULT_US;
            ctrl_r      <= `RST_CTRL;
            irq_mask_r  <= 8'h00;
            irq_stat_r  <= 8'h00;
            prdata      <= 32'h0000_0000;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
        end else begin
            // One wait state; read data is registered meanwhile
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~addr_ok;
            if (psel & penable & ~pready & ~pwrite) begin
                prdata <= rd_nxt;
            end
            if (wr_en & addr_ok) begin
                case (paddr)
                    `OFS_FUNC_LO: func_lo_r <= pwdata;
                    `OFS_FUNC_HI: func_hi_r <= pwdata;
                    `OFS_FILTER: begin
                        // Clamp at one second
                        if (pwdata > `FILTER_MAX_US) begin
                            filter_us_r <= `FILTER_MAX_US;
                        end else begin
                            filter_us_r <= pwdata;
                        end
                    end
                    `OFS_CTRL:     ctrl_r <= pwdata;
                    `OFS_IRQ_MASK: irq_mask_r <= pwdata[7:0];
                    // Levels and live source are read-only
                    `OFS_TERM, `OFS_CMD: ;
                    default: ;
                endcase
            end
            // Set wins over write-one clear
            if (wr_en && paddr == `OFS_IRQ_STAT) begin
                irq_stat_r <= (irq_stat_r & ~pwdata[7:0]) | irq_evt;
            end else begin
                irq_stat_r <= irq_stat_r | irq_evt;
            end
            if (rd_en) begin
                prdata <= prdata;
            end
        end
    end

    // Switch request level for command source
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cmd_toggle_r <= 1'b0;
        end else begin
            // Level held: source stays swapped while terminal is on
            cmd_toggle_r <= fn[`FN_CMD_SWITCH];
        end
    end

    // Registered strobes to the control core
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pulse_freq_en       <= 1'b0;
            pulse_freq_in       <= 1'b0;
            dc_brake_now        <= 1'b0;
            external_fault_code <= 1'b0;
            fault_stop          <= 1'b0;
            fault_protect_req   <= 1'b0;
            pid_dir_reverse     <= 1'b0;
            panel_stop          <= 1'b0;
            cmd_source          <= `CMD_SRC_PANEL;
            pid_int_hold        <= 1'b0;
            src_x_keypad        <= 1'b0;
            src_y_keypad        <= 1'b0;
            pid_gain_set2       <= 1'b0;
            emerg_stop          <= 1'b0;
            decel_stop          <= 1'b0;
            decel_set           <= 2'd0;
            length_reset        <= 1'b0;
        end else begin
            pulse_freq_en <= (codes[29:24] == `FN_PULSE_IN);
            pulse_freq_in <= (codes[29:24] == `FN_PULSE_IN) & pulse_s2_r;
            dc_brake_now <= fn[`FN_DC_BRAKE];
            external_fault_code <= fault_nxt;
            fault_stop          <= fn[`FN_EXT_FAULT_NC];
            fault_protect_req   <= fn[`FN_EXT_FAULT_NO];
            pid_dir_reverse <= ctrl_r[`CTRL_PID_DIR] ^ fn[`FN_PID_REVERSE];
            panel_stop <= fn[`FN_EXT_STOP1] &
                          (src_nxt == `CMD_SRC_PANEL);
            cmd_source <= src_nxt;
            pid_int_hold <= fn[`FN_PID_INT_HOLD];
            src_x_keypad <= fn[`FN_SRC_X_KEYPAD];
            src_y_keypad <= fn[`FN_SRC_Y_KEYPAD];
            pid_gain_set2 <= ctrl_r[`CTRL_GAIN_BY_TERM] & fn[`FN_PID_GAIN_SEL];
            emerg_stop <= fn[`FN_EMERG_STOP];
            // stop with decel set four, any mode
            decel_stop <= fn[`FN_EXT_STOP2];
            decel_set  <= fn[`FN_EXT_STOP2] ? `DECEL_SET_STOP2 : 2'd0;
            length_reset <= fn[`FN_LEN_RESET];
        end
    end

    // Interrupt level; lags status by a cycle, so a clear drops it next edge
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end

endmodule

`default_nettype wire

// ### itd_checker.sv
`timescale 1ns/100ps
`default_nettype none
module itd_checker (
    // Clock and reset
    input wire logic       clk,
    input wire logic       resetn,
    // Bus handshake
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    // Core strobes
    input wire logic       pulse_freq_en,
    input wire logic       pulse_freq_in,
    input wire logic       external_fault_code,
    input wire logic       fault_stop,
    input wire logic       fault_protect_req,
    input wire logic       panel_stop,
    input wire logic [1:0] cmd_source,
    input wire logic       decel_stop,
    input wire logic [1:0] decel_set
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Bus phases
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable; endsequence
    property p_answer; s_setup ##1 s_access |-> ##[0:2] pready; endproperty
    property p_one_cycle; pready |=> !pready; endproperty
    property p_err_ready; pslverr |-> pready; endproperty
    property p_stop4; decel_stop |-> decel_set == 2'h3; endproperty
    property p_nostop; !decel_stop |-> decel_set == 2'h0; endproperty
    property p_fault_nc; fault_stop |-> external_fault_code; endproperty
    property p_fault_no; fault_protect_req |-> external_fault_code; endproperty
    // Gate and enable are registered on the same edge; the check still allows one cycle
    property p_pulse; !pulse_freq_en && !$past(pulse_freq_en) |-> !pulse_freq_in; endproperty
    property p_panel;
        panel_stop |-> cmd_source == 2'h0 || $past(cmd_source) == 2'h0;
    endproperty
    property p_source; cmd_source != 2'h3; endproperty
    a_answer: assert property (p_answer) else $error("pready late");
    a_one_cycle: assert property (p_one_cycle) else $error("pready held");
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    a_stop4: assert property (p_stop4) else $error("wrong decel set");
    a_nostop: assert property (p_nostop) else $error("decel set idle");
    a_fault_nc: assert property (p_fault_nc) else $error("nc fault flag");
    a_fault_no: assert property (p_fault_no) else $error("no fault flag");
    a_pulse: assert property (p_pulse) else $error("pulse not gated");
    a_panel: assert property (p_panel) else $error("panel stop mode");
    a_source: assert property (p_source) else $error("bad source");
endmodule
bind input_terminal_function_decoder itd_checker chk (.clk(clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .pulse_freq_en(pulse_freq_en), .pulse_freq_in(pulse_freq_in),
    .external_fault_code(external_fault_code), .fault_stop(fault_stop),
    .fault_protect_req(fault_protect_req), .panel_stop(panel_stop),
    .cmd_source(cmd_source), .decel_stop(decel_stop), .decel_set(decel_set));
`default_nettype wire

// ### terminal_switches.sv
`timescale 1ns/100ps
`default_nettype none
module terminal_switches (
    // Clock
    input  wire logic       clk,
    // Requested contacts
    input  wire logic [4:0] want,
    // Terminal levels
    output var  logic [4:0] pins
);
    // Contacts move on an edge; glitches come from the bench itself
    initial pins = 5'h00;
    always @(posedge clk) begin
        pins <= want;
    end
endmodule
`default_nettype wire

// ### test_input_terminal_function_decoder.sv
`timescale 1ns/100ps
`default_nettype none
`include "mfi_defines.vh"
module test_input_terminal_function_decoder;
    logic        clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, seed = 32'h0000_0059, r;
    logic [4:0]  want = 5'h00;
    wire  logic [4:0] pins;
    logic [31:0] prdata;
    logic [1:0]  cmd_source, decel_set;
    logic        pready, pslverr, pulse_freq_en, pulse_freq_in, dc_brake_now, e;
    logic        external_fault_code, fault_stop, fault_protect_req, pid_dir_reverse;
    logic        panel_stop, pid_int_hold, src_x_keypad, src_y_keypad, pid_gain_set2;
    logic        emerg_stop, decel_stop, length_reset, irq;
    logic [3:0]  ctl;
    logic [18:0] exp_now;
    int          err_total = 0, compares = 0, c, t;
    int          codes[22] = '{28,29,30,31,32,33,34,35,36,37,38,39,40,41,42,43,44,45,46,47,48,11};
    wire  logic [18:0] outs = {pulse_freq_en, pulse_freq_in, dc_brake_now, external_fault_code,
        fault_stop, fault_protect_req, pid_dir_reverse, panel_stop, cmd_source, pid_int_hold,
        src_x_keypad, src_y_keypad, pid_gain_set2, emerg_stop, decel_stop, decel_set, length_reset};
    // Free running clock
    always #5 clk = ~clk;
    terminal_switches sw (.clk(clk), .want(want), .pins(pins));
    input_terminal_function_decoder dut (.clk(clk), .resetn(resetn),
        .multifunction_input(pins), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pulse_freq_en(pulse_freq_en), .pulse_freq_in(pulse_freq_in),
        .dc_brake_now(dc_brake_now), .external_fault_code(external_fault_code),
        .fault_stop(fault_stop), .fault_protect_req(fault_protect_req),
        .pid_dir_reverse(pid_dir_reverse), .panel_stop(panel_stop),
        .cmd_source(cmd_source), .pid_int_hold(pid_int_hold), .src_x_keypad(src_x_keypad),
        .src_y_keypad(src_y_keypad), .pid_gain_set2(pid_gain_set2),
        .emerg_stop(emerg_stop), .decel_stop(decel_stop), .decel_set(decel_set),
        .length_reset(length_reset), .irq(irq));
    function logic [31:0] next_rand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected strobes for one code on one terminal
    function automatic logic [18:0] exp_out(int c, int t, logic on, logic [3:0] ctl);
        logic [1:0] s;
        s = ctl[1:0];
        if (on && c == 37) s = (s == 2'h1) ? 2'h2 : (s == 2'h2) ? 2'h1 : s;
        return {c == 30 && t == 5, on && c == 30 && t == 5, on && c == 32,
            on && (c == 33 || c == 11), on && c == 33, on && c == 11, ctl[2] ^ (on && c == 35),
            on && c == 36 && ctl[1:0] == 2'h0, s, on && c == 38, on && c == 39, on && c == 40,
            ctl[3] && on && c == 43, on && c == 47, on && c == 48,
            (on && c == 48) ? 2'h3 : 2'h0, on && c == 28};
    endfunction
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task tally_and_finish;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One bus transfer, held until pready is seen at an edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] rd, output logic er);
        int n;
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            check("pready", 1, 0);
            tally_and_finish;
        end else begin
            rd = prdata; er = pslverr; psel <= 0; penable <= 0;
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1, a, d, r, e);
    endtask
    task settle;
        repeat (30) @(posedge clk);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1;
        apb(0, `OFS_FILTER, 0, r, e); check("filter reset", 32'h0000_2710, r);
        apb(0, `OFS_CTRL, 0, r, e); check("ctrl reset", 0, r);
        apb(0, 12'h040, 0, r, e); check("unmapped", 1, e);
        wr(`OFS_FILTER, 32'h001E_8480);
        apb(0, `OFS_FILTER, 0, r, e); check("filter clamp", 32'h000F_4240, r);
        // A 20-cycle glitch must not pass a 100-cycle filter
        wr(`OFS_FILTER, 1); wr(`OFS_FUNC_LO, 32);
        want <= 5'h01; repeat (20) @(posedge clk); want <= 5'h00; settle;
        check("glitch", 0, dc_brake_now);
        want <= 5'h01; repeat (150) @(posedge clk);
        check("held", 1, dc_brake_now);
        want <= 5'h00; wr(`OFS_FILTER, 0);
        // Every code twice, random terminal and control word
        for (int k = 0; k < 44; k++) begin
            c = codes[k % 22]; r = next_rand(); t = r[7:4] % 5 + 1;
            ctl = {r[3:2], (r[1:0] == 2'h3) ? 2'h0 : r[1:0]};
            wr(`OFS_CTRL, {28'h0, ctl});
            wr(`OFS_FUNC_LO, (t == 5) ? 0 : c << ((t == 4) ? 24 : 6 * (t - 1)));
            wr(`OFS_FUNC_HI, (t == 5) ? c : 0);
            for (int j = 1; j >= 0; j--) begin
                want <= j[0] << (t - 1); settle;
                exp_now = exp_out(c, t, j[0], ctl);
                check("strobes", exp_now, outs);
                apb(0, `OFS_TERM, 0, r, e); check("levels", j[0] << (t - 1), r);
                apb(0, `OFS_CMD, 0, r, e); check("source", exp_now[10:9], r);
            end
        end
        // A source code of 3 is not legal and falls back to panel
        wr(`OFS_CTRL, 32'h0000_0003);
        apb(0, `OFS_CMD, 0, r, e);
        check("source fallback", 0, r);
        // Sticky status, mask and clear
        wr(`OFS_IRQ_STAT, 32'h0000_00FF); wr(`OFS_IRQ_MASK, 32'h0000_0010);
        wr(`OFS_FUNC_HI, 0); wr(`OFS_FUNC_LO, 32);
        want <= 5'h01; settle; want <= 5'h00; settle;
        check("irq sticky", 1, irq);
        wr(`OFS_IRQ_MASK, 0); repeat (3) @(posedge clk); check("irq masked", 0, irq);
        wr(`OFS_IRQ_MASK, 32'h0000_0010); repeat (3) @(posedge clk); check("irq again", 1, irq);
        wr(`OFS_IRQ_STAT, 32'h0000_0010); repeat (3) @(posedge clk); check("irq clear", 0, irq);
        apb(0, `OFS_IRQ_STAT, 0, r, e); check("stat clear", 0, r);
        tally_and_finish;
    end
endmodule
`default_nettype wire
